/* File: verilog/pcsi_pkg.sv */
// Purpose: constants for the program counter, stack and indirect block
// Assumes: 32-bit apb register window, 40 MHz core clock
// Notes: offsets are word indexes; the byte address is four times the index
// Behaviour
// - program counter is 13 bits; low byte readable and writable
// - software changes upper pc bits only through the holding latch
// - low byte write copies latch bits 4:0 into upper pc bits
// - jump and call take 11 instruction bits plus latch bits 4:3
// - call or interrupt pushes full 13-bit pc onto stack
// - return, literal return and interrupt return pop into pc
// - stack holds 8 entries of 13 bits, outside memory spaces
// - stack pointer cannot be read or written by software
// - push and pop leave the holding latch unchanged
// - stack wraps circularly; ninth push overwrites the first
// - latch bits 2:0 are ignored when forming jump and call addresses
// - indirect location accesses file address held in pointer
// - pointer zero makes indirect read return 00h
// - writing indirect location through itself is a no-operation
// - effective address is bank bit above 8-bit pointer; bank unused
// - power control holds power-on and brown-out reset flags
// - brown-out flag cleared on brown-out, set by software
// - brown-out flag meaningless when detection is disabled
package pcsi_pkg;
    // ****************************************
    // register map
    // ****************************************
    // the power word index is not word aligned, so all offsets are indexes
    localparam int PCSI_ADDR_W = 10;
    localparam logic [7:0] PCSI_IDX_INDIRECT = 8'h00;
    localparam logic [7:0] PCSI_IDX_PC_LOW = 8'h02;
    localparam logic [7:0] PCSI_IDX_POINTER = 8'h04;
    localparam logic [7:0] PCSI_IDX_LATCH = 8'h0C;
    localparam logic [7:0] PCSI_IDX_STATUS = 8'h10;
    localparam logic [7:0] PCSI_IDX_POWER = 8'h8E;
    localparam logic [9:0] PCSI_OFF_INDIRECT = {PCSI_IDX_INDIRECT, 2'b00};
    localparam logic [9:0] PCSI_OFF_PC_LOW = {PCSI_IDX_PC_LOW, 2'b00};
    localparam logic [9:0] PCSI_OFF_POINTER = {PCSI_IDX_POINTER, 2'b00};
    localparam logic [9:0] PCSI_OFF_LATCH = {PCSI_IDX_LATCH, 2'b00};
    localparam logic [9:0] PCSI_OFF_STATUS = {PCSI_IDX_STATUS, 2'b00};
    localparam logic [9:0] PCSI_OFF_POWER = {PCSI_IDX_POWER, 2'b00};
    // ****************************************
    // fields and widths
    // ****************************************
    localparam int PCSI_PC_W = 13;
    localparam int PCSI_JMP_W = 11;
    localparam int PCSI_STK_DEPTH = 8;
    localparam int PCSI_POWER_POR_BIT = 1;
    localparam int PCSI_POWER_BROWNOUT_BIT = 0;
    localparam int PCSI_BANK_BIT = 7;
    localparam logic [7:0] PCSI_ZERO_BYTE = 8'h00;
    localparam logic [12:0] PCSI_PC_RESET = 13'h0;
    localparam logic [4:0] PCSI_LATCH_RESET = 5'h00;
    localparam logic [31:0] PCSI_ERR_DATA = 32'h00000000;
endpackage

/* File: verilog/pcsi_core.sv */
// Purpose: program counter, return stack, indirect address and reset flags
// Assumes: decoder gives one-cycle control pulses; apb for software access
// Notes: apb slave answers with zero wait states
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
module pcsi_core
    import pcsi_pkg::*;
#(
    parameter int DEPTH = PCSI_STK_DEPTH
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // reset causes
    input wire logic i_por,
    input wire logic i_brownout_event,
    input wire logic i_brownout_detect_enable,
    // decoder controls
    input wire logic i_fetch,
    input wire logic i_jump,
    input wire logic i_call,
    input wire logic i_int_branch,
    input wire logic [12:0] i_int_vector,
    input wire logic i_return,
    input wire logic [10:0] i_instr_addr,
    // data path indirect access
    input wire logic i_indirect_rd,
    input wire logic i_indirect_wr,
    input wire logic [7:0] i_rf_rdata,
    // apb
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [PCSI_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // outputs
    output logic [12:0] o_pc,
    output logic [8:0] o_rf_addr,
    output logic o_rf_wr_en,
    output logic [7:0] o_indirect_rdata
);
    // ****************************************
    // state
    // ****************************************
    // pointer wraps modulo depth, so depth must be a power of two
    localparam int SPW = $clog2(DEPTH);
    logic [12:0] pc_q;
    logic [4:0] upper_address_holding_latch_q;
    logic [7:0] pointer_register_q;
    logic indirect_bank_bit_q;
    logic por_flag_q;
    logic brownout_flag_q;
    logic [12:0] stack_q [DEPTH];
    logic [SPW-1:0] sp_q;
    logic wr_acc;
    logic rd_setup;
    logic hit_low;
    logic hit_pointer;
    logic hit_latch;
    logic hit_status;
    logic hit_power;
    logic low_wr;
    logic push;
    logic [12:0] top;
    logic [12:0] paged_addr;
    logic [31:0] prdata_d;

    // ****************************************
    // address decode
    // ****************************************
    assign wr_acc = i_psel && i_penable && i_pwrite;
    // read data is captured in setup so it stands for the access phase
    assign rd_setup = i_psel && !i_penable && !i_pwrite;
    assign hit_low = (i_paddr == PCSI_OFF_PC_LOW);
    assign hit_pointer = (i_paddr == PCSI_OFF_POINTER);
    assign hit_latch = (i_paddr == PCSI_OFF_LATCH);
    assign hit_status = (i_paddr == PCSI_OFF_STATUS);
    assign hit_power = (i_paddr == PCSI_OFF_POWER);
    assign low_wr = wr_acc && hit_low;
    assign push = i_call || i_int_branch;
    // top entry sits one below the pointer
    assign top = stack_q[sp_q - SPW'(1)];
    // latch bits 2:0 take no part in paging
    assign paged_addr = {upper_address_holding_latch_q[4:3], i_instr_addr};

    // ****************************************
    // program counter
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pc_q <= PCSI_PC_RESET;
        end else if (i_return) begin
            pc_q <= top;
        end else if (i_int_branch) begin
            pc_q <= i_int_vector;
        end else if (i_jump || i_call) begin
            pc_q <= paged_addr;
        end else if (low_wr) begin
            pc_q <= {upper_address_holding_latch_q, i_pwdata[7:0]};
        end else if (i_fetch) begin
            pc_q <= pc_q + 13'h0001;
        end
    end
    assign o_pc = pc_q;

    // ****************************************
    // return stack
    // ****************************************
    // private circular stack
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sp_q <= '0;
        end else if (push) begin
            // no overflow flag: the oldest entry is simply overwritten
            sp_q <= sp_q + SPW'(1);
        end else if (i_return) begin
            sp_q <= sp_q - SPW'(1);
        end
    end

    for (genvar g = 0; g < DEPTH; g++) begin : g_stack
        localparam logic [SPW-1:0] SLOT = SPW'(g);
        always_ff @(posedge i_clk) begin
            if (push && (sp_q == SLOT)) begin
                stack_q[g] <= pc_q;
            end
        end
    end

    // ****************************************
    // software registers
    // ****************************************
    // latch only written by software
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            upper_address_holding_latch_q <= PCSI_LATCH_RESET;
            pointer_register_q <= PCSI_ZERO_BYTE;
            indirect_bank_bit_q <= 1'b0;
        end else if (wr_acc) begin
            if (hit_latch) begin
                upper_address_holding_latch_q <= i_pwdata[4:0];
            end
            if (hit_pointer) begin
                pointer_register_q <= i_pwdata[7:0];
            end
            if (hit_status) begin
                indirect_bank_bit_q <= i_pwdata[PCSI_BANK_BIT];
            end
        end
    end

    // reset cause flags
    // flags survive core reset; power-on clears both, a brown-out with detection enabled clears only the brown-out flag
    // a brown-out with detection enabled in the cycle of a software write beats the write
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            por_flag_q <= 1'b0;
            brownout_flag_q <= 1'b0;
        end else if (i_brownout_event && i_brownout_detect_enable) begin
            brownout_flag_q <= 1'b0;
        end else if (wr_acc && hit_power) begin
            por_flag_q <= i_pwdata[PCSI_POWER_POR_BIT];
            brownout_flag_q <= i_pwdata[PCSI_POWER_BROWNOUT_BIT];
        end
    end

    // ****************************************
    // indirect addressing
    // ****************************************
    // effective address, bank bit unused
    assign o_rf_addr = {1'b0, pointer_register_q};
    assign o_rf_wr_en = i_indirect_wr && (pointer_register_q != 8'h00);
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_indirect_rdata <= PCSI_ZERO_BYTE;
        end else if (i_indirect_rd) begin
            o_indirect_rdata <= (pointer_register_q == 8'h00) ?
                PCSI_ZERO_BYTE : i_rf_rdata;
        end
    end

    // ****************************************
    // apb read path
    // ****************************************
    assign o_pready = 1'b1;
    assign o_pslverr = 1'b0;
    // upper pc bits and stack pointer have no address at all
    always_comb begin
        prdata_d = PCSI_ERR_DATA;
        unique case (i_paddr)
            PCSI_OFF_INDIRECT: prdata_d = PCSI_ERR_DATA;
            PCSI_OFF_PC_LOW: prdata_d = {24'h000000, pc_q[7:0]};
            PCSI_OFF_LATCH:
                prdata_d = {27'h0, upper_address_holding_latch_q};
            PCSI_OFF_POINTER: prdata_d = {24'h000000, pointer_register_q};
            PCSI_OFF_STATUS:
                prdata_d = {24'h000000, indirect_bank_bit_q, 7'h00};
            PCSI_OFF_POWER:
                prdata_d = {30'h0, por_flag_q, brownout_flag_q};
            default: prdata_d = PCSI_ERR_DATA;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_prdata <= PCSI_ERR_DATA;
        end else if (rd_setup) begin
            o_prdata <= prdata_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_low_write_load: assert property (
        @(posedge i_clk) disable iff (i_reset)
        low_wr && !i_return && !push && !i_jump
        |=> o_pc == {$past(upper_address_holding_latch_q),
        $past(i_pwdata[7:0])})
        else $error("low byte write did not load pc");

    a_fetch_incr: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_fetch && !i_return && !push && !i_jump && !low_wr
        |=> o_pc == $past(o_pc) + 13'h0001)
        else $error("pc did not increment");

    a_jump_page: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_jump && !i_return && !i_int_branch
        |=> o_pc == {$past(upper_address_holding_latch_q[4:3]),
        $past(i_instr_addr)})
        else $error("jump address wrong");

    a_call_return: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_call && !i_return && !i_int_branch ##1 (i_return && !push)
        |=> o_pc == $past(o_pc, 2))
        else $error("return did not restore pc");

    a_latch_stable: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (push || i_return) && !wr_acc
        |=> $stable(upper_address_holding_latch_q))
        else $error("latch changed by stack");

    a_indirect_zero: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_indirect_rd && pointer_register_q == 8'h00
        |=> o_indirect_rdata == 8'h00)
        else $error("indirect zero read not zero");

    a_indirect_nowr: assert property (
        @(posedge i_clk) disable iff (i_reset)
        pointer_register_q == 8'h00 |-> !o_rf_wr_en)
        else $error("self write not suppressed");

    a_indirect_addr: assert property (
        @(posedge i_clk) disable iff (i_reset)
        wr_acc && hit_pointer
        |=> o_rf_addr[7:0] == $past(i_pwdata[7:0]))
        else $error("pointer address wrong");

    a_brownout_clear: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_brownout_event && i_brownout_detect_enable && !i_por
        |=> !brownout_flag_q)
        else $error("brownout flag not cleared");

    a_call_page: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_call && !i_return && !i_int_branch
        |=> o_pc == $past(paged_addr))
        else $error("call address wrong");

    a_int_vector: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_int_branch && !i_return
        |=> o_pc == $past(i_int_vector))
        else $error("interrupt vector not loaded");

    a_push_entry: assert property (
        @(posedge i_clk) disable iff (i_reset)
        push
        |=> stack_q[$past(sp_q)] == $past(pc_q))
        else $error("pushed entry is not the pc");

    a_sp_advance: assert property (
        @(posedge i_clk) disable iff (i_reset)
        push
        |=> sp_q == $past(sp_q) + SPW'(1))
        else $error("stack pointer did not advance");

    a_sp_retreat: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_return && !push
        |=> sp_q == $past(sp_q) - SPW'(1))
        else $error("stack pointer did not retreat");

    a_return_load: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_return
        |=> o_pc == $past(top))
        else $error("return did not load top entry");

    a_pc_hold: assert property (
        @(posedge i_clk) disable iff (i_reset)
        !i_return && !push && !i_jump && !low_wr && !i_fetch
        |=> $stable(o_pc))
        else $error("pc changed without cause");

    a_latch_write: assert property (
        @(posedge i_clk) disable iff (i_reset)
        wr_acc && hit_latch
        |=> upper_address_holding_latch_q == $past(i_pwdata[4:0]))
        else $error("latch write lost");

    a_bank_unused: assert property (
        @(posedge i_clk) disable iff (i_reset)
        o_rf_addr[8] == 1'b0)
        else $error("bank bit reached the address");

    a_brownout_keep: assert property (
        @(posedge i_clk) disable iff (i_reset)
        !i_por && !i_brownout_detect_enable && !(wr_acc && hit_power)
        |=> $stable(brownout_flag_q))
        else $error("brownout flag moved while disabled");

    a_por_clear: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_por
        |=> !por_flag_q && !brownout_flag_q)
        else $error("power-on did not clear flags");

    a_indirect_pass: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_indirect_rd && pointer_register_q != 8'h00
        |=> o_indirect_rdata == $past(i_rf_rdata))
        else $error("indirect read data wrong");

    a_indirect_wr_pass: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_indirect_wr && pointer_register_q != 8'h00 |-> o_rf_wr_en)
        else $error("indirect write dropped");

    a_pointer_hold: assert property (
        @(posedge i_clk) disable iff (i_reset)
        !(wr_acc && hit_pointer)
        |=> $stable(pointer_register_q))
        else $error("pointer changed without a write");
endmodule

/* File: verif/pcsi_rf_model.sv */
// Purpose: register file behind the indirect port
// Assumes: combinational read at the pointer address
// Notes: contents are a fixed pattern of the address
`timescale 1ns/10ps
module pcsi_rf_model (
    // address in
    input wire logic [8:0] i_addr,
    // data out
    output logic [7:0] o_rdata
);
    assign o_rdata = i_addr[7:0] ^ 8'h5A;
endmodule

/* File: verif/pcsi_core_tb.sv */
// Purpose: self-checking bench for the pc, stack and indirect block
// Assumes: zero-wait apb, one-cycle decoder pulses
// Notes: pulses are spaced by an idle cycle to keep drivers simple, except the back-to-back call and return
`timescale 1ns/10ps
module pcsi_core_tb
    import pcsi_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic por = 1'b1;
    logic bev = 1'b0;
    logic bden = 1'b1;
    logic [6:0] ctl = 7'h00;
    logic [12:0] vec = 13'h1ABC;
    logic [10:0] ia = 11'h000;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [9:0] padr = 10'h000;
    logic [31:0] pwd = 32'h00000000;
    logic [31:0] rd;
    logic pready, pslverr, wr_en;
    logic [31:0] prdata;
    logic [12:0] pc;
    logic [8:0] rf_addr;
    logic [7:0] rf_rdata, ind_rdata;
    int num_errors = 0;
    int num_checks = 0;
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end
    pcsi_core dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_por(por),
        .i_brownout_event(bev), .i_brownout_detect_enable(bden),
        .i_fetch(ctl[0]), .i_jump(ctl[1]), .i_call(ctl[2]),
        .i_int_branch(ctl[3]), .i_int_vector(vec), .i_return(ctl[4]),
        .i_instr_addr(ia), .i_indirect_rd(ctl[5]),
        .i_indirect_wr(ctl[6]), .i_rf_rdata(rf_rdata), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd),
        .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .o_pc(pc), .o_rf_addr(rf_addr), .o_rf_wr_en(wr_en),
        .o_indirect_rdata(ind_rdata));
    pcsi_rf_model rf_u (.i_addr(rf_addr), .o_rdata(rf_rdata));
    task chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // apb transfer, entered and left just after a rising edge
    task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        n = 0;
        @(posedge i_clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                num_errors++;
                results;
            end
            @(posedge i_clk);
        end
        rd = prdata;
        chk("pslverr", {31'h0, pslverr}, 32'h0);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge i_clk);
    endtask
    // one decoder pulse; op returns 1 ns after the edge, caller checks, then waits one more edge
    task op(input int b, input logic [10:0] a);
        ctl <= 7'h01 << b;
        ia <= a;
        @(posedge i_clk);
        ctl <= 7'h00;
        #1;
    endtask
    task wr_try(input logic exp);
        ctl <= 7'h40;
        #1;
        chk("wr_en", {31'h0, wr_en}, {31'h0, exp});
        @(posedge i_clk);
        ctl <= 7'h00;
        @(posedge i_clk);
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        por <= 1'b0;
        @(posedge i_clk);
        chk("pc", {19'h0, pc}, 32'h0);
        apb(1'b1, PCSI_OFF_LATCH, 32'h1F);
        apb(1'b1, PCSI_OFF_PC_LOW, 32'hFF);
        chk("pc", {19'h0, pc}, 32'h1FFF);
        apb(1'b0, PCSI_OFF_PC_LOW, 32'h0);
        chk("pc_low", rd, 32'hFF);
        apb(1'b1, PCSI_OFF_LATCH, 32'h02);
        apb(1'b1, PCSI_OFF_PC_LOW, 32'hFF);
        op(0, 11'h000);
        chk("pc", {19'h0, pc}, 32'h0300);
        @(posedge i_clk);
        // page bits set before the jump
        apb(1'b1, PCSI_OFF_LATCH, 32'h08);
        op(1, 11'h555);
        chk("pc", {19'h0, pc}, 32'h0D55);
        @(posedge i_clk);
        for (int k = 0; k < 9; k++) begin
            op(2, 11'(k + 1));
            chk("pc", {19'h0, pc}, 32'h0801 + k);
            @(posedge i_clk);
        end
        for (int k = 0; k < 9; k++) begin
            op(4, 11'h000);
            chk("pc", {19'h0, pc}, 32'h0808 - (k % 8));
            @(posedge i_clk);
        end
        apb(1'b0, PCSI_OFF_LATCH, 32'h0);
        chk("latch", rd, 32'h08);
        op(3, 11'h000);
        chk("pc", {19'h0, pc}, 32'h1ABC);
        @(posedge i_clk);
        op(4, 11'h000);
        chk("pc", {19'h0, pc}, 32'h0808);
        @(posedge i_clk);
        // call then return on the very next cycle
        ctl <= 7'h04;
        ia <= 11'h123;
        @(posedge i_clk);
        ctl <= 7'h10;
        @(posedge i_clk);
        ctl <= 7'h00;
        #1;
        chk("pc", {19'h0, pc}, 32'h0808);
        @(posedge i_clk);
        apb(1'b1, PCSI_OFF_POINTER, 32'h05);
        apb(1'b1, PCSI_OFF_STATUS, 32'h80);
        chk("rf_addr", {23'h0, rf_addr}, 32'h005);
        op(5, 11'h000);
        chk("ind", {24'h0, ind_rdata}, 32'h5F);
        @(posedge i_clk);
        wr_try(1'b1);
        apb(1'b1, PCSI_OFF_POINTER, 32'h00);
        op(5, 11'h000);
        chk("ind", {24'h0, ind_rdata}, 32'h00);
        @(posedge i_clk);
        wr_try(1'b0);
        apb(1'b0, PCSI_OFF_POWER, 32'h0);
        chk("power_ctl", rd, 32'h00);
        // software marks the flags after power-up
        apb(1'b1, PCSI_OFF_POWER, 32'h03);
        bev <= 1'b1;
        @(posedge i_clk);
        bev <= 1'b0;
        @(posedge i_clk);
        apb(1'b0, PCSI_OFF_POWER, 32'h0);
        chk("power_ctl", rd, 32'h02);
        // brown-out with detection off leaves the flag alone
        apb(1'b1, PCSI_OFF_POWER, 32'h03);
        bden <= 1'b0;
        bev <= 1'b1;
        @(posedge i_clk);
        bev <= 1'b0;
        bden <= 1'b1;
        @(posedge i_clk);
        apb(1'b0, PCSI_OFF_POWER, 32'h0);
        chk("power_ctl", rd, 32'h03);
        apb(1'b0, 10'h100, 32'h0);
        chk("unmapped", rd, 32'h0);
        results;
    end
endmodule
